// [rtl/adc_spi_crc_command_port.sv]
`timescale 1ns/1ps
// Functional notes
// (RULE1) CRC words are 16 bits and cover every bit of protected words.
// (RULE2) input CRC check is optional and disabled after reset.
// (RULE3) on input CRC mismatch only register write still executes.
// (RULE4) any input CRC mismatch sets the CRC error status flag.
// (RULE5) frame after a CRC error answers with the no-op response.
// (RULE6) CRC error flag clears once the status word has been sent.
// (RULE7) every output frame ends with an output CRC word.
// (RULE8) one select picks CCITT 1021h or ANSI 8005h for both directions.
// (RULE9) every CRC starts from seed FFFFh.
// (RULE10) enabled timeout resets serial logic after 2^15 main clocks.
// (RULE11) after timeout the next SCLK edge starts a new frame.
// (RULE12) status holds four ready bits and answers the no-op command.
// (RULE13) 24-bit results: truncated at 16, zero padded or sign extended at 32.
// (RULE14) results clip at 7FFFFFh and 800000h.
// (RULE15) decode no-op, reset, standby; standby echoes its word.
// (RULE16) decode wakeup, lock, unlock; each echoes its word.
// (RULE17) while locked only no-op, unlock and register read act.
// (RULE18) register read: single gives data, multiple gives 111 header then data.
// (RULE19) register write answers 010, address and written count minus one.
// (RULE20) no-op changes nothing; unknown words answer like no-op.
// (RULE21) reset acts only on full frame, answers FF44h, else 0011h.
// (RULE22) host waits settle time or ready edge after a reset.
// (RULE23) word length 16, 24 or 32, default 24; 16-bit words MSB aligned.
// (RULE24) six-word frame: response, four results, output CRC.
// (RULE25) serial state resets whenever chip select goes high.
// (RULE26) CRC is MSB first with no final inversion.
`include "adc_spi_regs.svh"
module adc_spi_crc_command_port import adc_spi_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_MCLK
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic [1:0] word_length_select,
  input wire logic rx_crc_en,
  input wire logic crc_type,
  input wire logic timeout_en,
  input wire raw_t [3:0] channel_raw,
  input wire logic [3:0] channel_ready_bits,
  input wire word16_t [63:0] reg_image,
  input wire logic reg_wr_ok,
  output logic reg_wr_valid,
  output logic [5:0] reg_wr_addr,
  output logic [15:0] reg_wr_data,
  output logic dev_reset_req,
  output logic standby_req,
  output logic wakeup_req,
  output logic interface_locked,
  output logic crc_error_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // serial crc, msb first, no final inversion
  // (RULE8) one select, both directions
  function automatic word16_t crc_step(word16_t c, logic b, logic ansi);
    word16_t p;
    p = ansi ? `POLY_ANSI : `POLY_CCITT;
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0000);
  endfunction : crc_step

  function automatic logic [4:0] bit_last(logic [1:0] wl);
    case (wl)
      `WL_16: bit_last = 5'h0f;
      `WL_24: bit_last = 5'h17;
      default: bit_last = 5'h1f;
    endcase
  endfunction : bit_last

  // result word, left aligned in 32 bits
  function automatic logic [31:0] fmt_code(code_t c, logic [1:0] wl);
    case (wl)
      `WL_16: fmt_code = {c[23:8], 16'h0000};
      `WL_32_SIGN: fmt_code = {{8{c[23]}}, c};
      default: fmt_code = {c, 8'h00};
    endcase
  endfunction : fmt_code

  function automatic code_t clamp(raw_t r);
    if (r > `RAW_MAX) clamp = `CODE_MAX;
    else if (r < `RAW_MIN) clamp = `CODE_MIN;
    else clamp = r[23:0];
  endfunction : clamp

  function automatic cmd_kind_t decode(word16_t c);
    if (c[15:13] == `OP_REGISTER_READ_CMD) decode = K_REGISTER_READ_CMD;
    else if (c[15:13] == `OP_REGISTER_WRITE_CMD) decode = K_REGISTER_WRITE_CMD;
    else begin
      case (c)
        `CMD_RESET: decode = K_RESET;
        `CMD_STANDBY: decode = K_STANDBY;
        `CMD_WAKEUP: decode = K_WAKEUP;
        `CMD_LOCK: decode = K_LOCK;
        `CMD_UNLOCK: decode = K_UNLOCK;
        default: decode = K_NOOP;
      endcase
    end
  endfunction : decode

  localparam rx_t RX_RST = '{crc: `CRC_SEED, default: '0};
  localparam tx_t TX_RST = '{crc: `CRC_SEED, default: '0};

  rx_t rx_q, rx_d;
  res_t res_q, res_d;
  tx_t tx_q, tx_d;
  sys_t sys_q, sys_d;
  logic link_rst_n;

  // ----------------------------------------------------------------
  // link reset
  // ----------------------------------------------------------------
  // (RULE25) chip select high
  // (RULE10) timeout also clears
  assign link_rst_n = arst_n & ~cs_n & ~sys_q.tmo;

  // ----------------------------------------------------------------
  // receive side, falling sclk
  // ----------------------------------------------------------------
  // snapshot fields are frozen by the system side while cs_n is low
  always_comb begin
    logic [4:0] last;
    logic [7:0] crc_idx;
    logic is_wr;
    word16_t cur;
    rx_d = rx_q;
    res_d = res_q;
    last = bit_last(sys_q.snap.wl);
    is_wr = (rx_q.word_idx != 8'h00) && (res_q.cmd[15:13] == `OP_REGISTER_WRITE_CMD);
    crc_idx = is_wr ? ({1'b0, res_q.cmd[6:0]} + 8'h02) : 8'h01;
    cur = (rx_q.bit_cnt < 5'h10) ? {rx_q.sh[14:0], din} : rx_q.sh;
    // (RULE11) first edge after reset opens a frame
    if (!rx_q.started) begin
      res_d.words = 8'h00;
      res_d.crc_bad = 1'b0;
      res_d.crc_seen = 1'b0;
    end
    rx_d.started = 1'b1;
    rx_d.sh = cur;
    // (RULE1) padding bits included
    if (rx_q.word_idx != crc_idx) rx_d.crc = crc_step(rx_q.crc, din, sys_q.snap.crc_type);
    if (rx_q.bit_cnt == last) begin
      rx_d.bit_cnt = 5'h00;
      if (rx_q.word_idx != 8'hff) rx_d.word_idx = rx_q.word_idx + 8'h01;
      res_d.words = rx_d.word_idx;
      if (rx_q.word_idx == 8'h00) res_d.cmd = cur;
      // (RULE2) compare only when enabled
      if (sys_q.snap.rx_crc_en && rx_q.word_idx == crc_idx) begin
        res_d.crc_seen = 1'b1;
        res_d.crc_bad = (cur != rx_q.crc);
      end
      // (RULE3) writes go out as shifted in
      if (is_wr && rx_q.word_idx <= ({1'b0, res_q.cmd[6:0]} + 8'h01)) begin
        res_d.wr_addr = res_q.cmd[12:7] + rx_q.word_idx[5:0] - 6'h01;
        res_d.wr_data = cur;
        res_d.wr_tgl = ~res_q.wr_tgl;
      end
    end else begin
      rx_d.bit_cnt = rx_q.bit_cnt + 5'h01;
    end
  end

  // (RULE9) seed on every frame
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) rx_q <= RX_RST;
    else rx_q <= rx_d;
  end

  // results outlive the frame so the system side can read them after cs_n rises
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) res_q <= '0;
    else res_q <= res_d;
  end

  // ----------------------------------------------------------------
  // transmit side, rising sclk
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] last;
    logic [7:0] n;
    logic [7:0] crc_at;
    logic [7:0] idx;
    logic [31:0] w;
    logic [31:0] sh;
    tx_d = tx_q;
    w = 32'h0000_0000;
    last = bit_last(sys_q.snap.wl);
    n = sys_q.snap.rd_cnt;
    idx = tx_q.word_idx;
    // (RULE24) response, four results, crc
    crc_at = (n != 8'h00) ? (n + 8'h01) : `CRC_WORD_STD;
    if (idx == 8'h00) w = {sys_q.snap.resp, 16'h0000};
    // (RULE7) crc word always appended
    else if (idx == crc_at) w = {tx_q.crc, 16'h0000};
    // (RULE18) register words replace results
    else if (n != 8'h00 && idx <= n)
      w = {sys_q.snap.regs[sys_q.snap.rd_base + idx[5:0] - 6'h01], 16'h0000};
    // (RULE13) result formatting
    else if (n == 8'h00 && idx <= `CHAN_WORDS)
      w = fmt_code(sys_q.snap.chan[idx[1:0] - 2'h1], sys_q.snap.wl);
    else w = 32'h0000_0000;
    sh = (tx_q.bit_cnt == 5'h00) ? w : tx_q.sh;
    tx_d.dout = sh[31];
    tx_d.sh = {sh[30:0], 1'b0};
    tx_d.oe = 1'b1;
    // (RULE26) msb first into the crc
    if (idx < crc_at) tx_d.crc = crc_step(tx_q.crc, sh[31], sys_q.snap.crc_type);
    if (tx_q.bit_cnt == last) begin
      tx_d.bit_cnt = 5'h00;
      if (idx != 8'hff) tx_d.word_idx = idx + 8'h01;
    end else begin
      tx_d.bit_cnt = tx_q.bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) tx_q <= TX_RST;
    else tx_q <= tx_d;
  end

  // ----------------------------------------------------------------
  // system side
  // ----------------------------------------------------------------
  always_comb begin
    word16_t status;
    cmd_kind_t kind;
    logic bad;
    logic allowed;
    sys_d = sys_q;
    allowed = 1'b0;
    sys_d.wr_v = 1'b0;
    sys_d.rst_p = 1'b0;
    sys_d.stby_p = 1'b0;
    sys_d.wake_p = 1'b0;
    // synchronisers
    sys_d.cs_m = cs_n;
    sys_d.cs_s = sys_q.cs_m;
    sys_d.act_m = rx_q.started;
    sys_d.act_s = sys_q.act_m;
    sys_d.wt_m = res_q.wr_tgl;
    sys_d.wt_s = sys_q.wt_m;
    // (RULE12) status word with ready bits
    status = {sys_q.locked, 2'h0, sys_q.crc_err, 2'h0, sys_q.snap.wl, 4'h0,
              channel_ready_bits};
    kind = decode(res_q.cmd);
    // (RULE4) mismatch detection
    bad = sys_q.snap.rx_crc_en && res_q.crc_seen && res_q.crc_bad;

    // register writes, one per toggle; the word holds for a whole word time
    if (sys_q.wt_s != sys_q.wt_seen) begin
      sys_d.wt_seen = sys_q.wt_s;
      // (RULE17) blocked while locked
      if (!sys_q.locked) begin
        sys_d.wr_v = 1'b1;
        sys_d.wr_addr = res_q.wr_addr;
        sys_d.wr_data = res_q.wr_data;
      end
    end
    if (sys_q.wr_v && reg_wr_ok && sys_q.wr_cnt != 8'hff) sys_d.wr_cnt = sys_q.wr_cnt + 8'h01;

    // (RULE10) frame length watchdog
    if (sys_q.tmo) begin
      sys_d.tmo_cnt = '0;
      sys_d.pend = 1'b0;
      if (!sys_q.act_s) sys_d.tmo = 1'b0;
    end else if (sys_q.act_s && !sys_q.cs_s) begin
      sys_d.pend = 1'b1;
      if (sys_q.tmo_cnt != 17'h1ffff) sys_d.tmo_cnt = sys_q.tmo_cnt + 17'h00001;
      if (timeout_en && sys_q.tmo_cnt >= 17'(TIMEOUT_CYCLES)) sys_d.tmo = 1'b1;
    end else begin
      sys_d.tmo_cnt = '0;
    end

    // idle: keep the snapshot fresh; cs_n low freezes it for the link
    if (sys_q.cs_s && !sys_q.pend) begin
      sys_d.end_cnt = 2'h0;
      // (RULE23) word length taken between frames
      sys_d.snap.wl = word_length_select;
      sys_d.snap.crc_type = crc_type;
      sys_d.snap.rx_crc_en = rx_crc_en;
      sys_d.snap.regs = reg_image;
      // (RULE14) clip results
      for (int i = 0; i < 4; i++) sys_d.snap.chan[i] = clamp(channel_raw[i]);
      if (sys_q.resp_st) sys_d.snap.resp = status;
    end

    // end of frame: let the last write land, then decode
    if (sys_q.cs_s && sys_q.pend && !sys_q.tmo) begin
      sys_d.end_cnt = sys_q.end_cnt + 2'h1;
      if (sys_q.end_cnt == `END_DELAY) begin
        sys_d.pend = 1'b0;
        sys_d.end_cnt = 2'h0;
        sys_d.wr_cnt = 8'h00;
        if (res_q.words != 8'h00) begin
          // (RULE6) cleared once sent; a new error wins
          sys_d.crc_err = (sys_q.resp_st ? 1'b0 : sys_q.crc_err) | bad;
          // (RULE5) status response after error
          sys_d.resp_st = 1'b1;
          sys_d.snap.rd_cnt = 8'h00;
          allowed = !sys_q.locked || kind == K_NOOP || kind == K_UNLOCK || kind == K_REGISTER_READ_CMD;
          // (RULE3) everything else suppressed
          if (!bad && allowed) begin
            case (kind)
              // (RULE21) full frame only
              K_RESET: begin
                sys_d.resp_st = 1'b0;
                if (res_q.words >= `FRAME_WORDS) begin
                  sys_d.rst_p = 1'b1;
                  sys_d.locked = 1'b0;
                  sys_d.crc_err = 1'b0;
                  sys_d.snap.resp = `RESP_RESET_OK;
                end else begin
                  sys_d.snap.resp = `RESP_RESET_SHORT;
                end
              end
              // (RULE15) standby echo
              K_STANDBY: begin
                sys_d.stby_p = 1'b1;
                sys_d.resp_st = 1'b0;
                sys_d.snap.resp = res_q.cmd;
              end
              // (RULE16) echo responses
              K_WAKEUP, K_LOCK, K_UNLOCK: begin
                sys_d.wake_p = (kind == K_WAKEUP);
                if (kind == K_LOCK) sys_d.locked = 1'b1;
                if (kind == K_UNLOCK) sys_d.locked = 1'b0;
                sys_d.resp_st = 1'b0;
                sys_d.snap.resp = res_q.cmd;
              end
              // (RULE18) single or multiple read
              K_REGISTER_READ_CMD: begin
                sys_d.resp_st = 1'b0;
                if (res_q.cmd[6:0] == 7'h00) begin
                  sys_d.snap.resp = reg_image[res_q.cmd[12:7]];
                end else begin
                  sys_d.snap.resp = {`OP_REGISTER_READ_CMD_MULTI, res_q.cmd[12:0]};
                  sys_d.snap.rd_cnt = {1'b0, res_q.cmd[6:0]} + 8'h01;
                  sys_d.snap.rd_base = res_q.cmd[12:7];
                  sys_d.snap.regs = reg_image;
                end
              end
              // (RULE19) count actually written
              K_REGISTER_WRITE_CMD: begin
                sys_d.resp_st = 1'b0;
                sys_d.snap.resp = {`OP_REGISTER_WRITE_CMD_ACK, res_q.cmd[12:7],
                                   sys_d_wr_m(sys_q.wr_cnt, sys_q.wr_v && reg_wr_ok)};
              end
              // (RULE20) no-op and unknown words
              default: sys_d.resp_st = 1'b1;
            endcase
          end
          if (sys_d.resp_st) sys_d.snap.resp = status;
        end
      end
    end
  end

  // written count minus one, including a write finishing this cycle
  function automatic logic [6:0] sys_d_wr_m(logic [7:0] cnt, logic inc);
    logic [7:0] t;
    t = cnt + {7'h00, inc} - 8'h01;
    sys_d_wr_m = t[6:0];
  endfunction : sys_d_wr_m

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) sys_q <= '{cs_m: 1'b1, cs_s: 1'b1, resp_st: 1'b1,
                            snap: '{wl: `WL_24, default: '0}, default: '0};
    else sys_q <= sys_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dout = tx_q.dout;
  assign dout_oe = tx_q.oe;
  assign reg_wr_valid = sys_q.wr_v;
  assign reg_wr_addr = sys_q.wr_addr;
  assign reg_wr_data = sys_q.wr_data;
  assign dev_reset_req = sys_q.rst_p;
  assign standby_req = sys_q.stby_p;
  assign wakeup_req = sys_q.wake_p;
  assign interface_locked = sys_q.locked;
  assign crc_error_flag = sys_q.crc_err;

endmodule : adc_spi_crc_command_port

// [rtl/adc_spi_pkg.sv]
package adc_spi_pkg;
  typedef logic [15:0] word16_t;
  typedef logic [23:0] code_t;
  typedef logic signed [27:0] raw_t;
  typedef enum logic [2:0] {
    K_NOOP, K_RESET, K_STANDBY, K_WAKEUP, K_LOCK, K_UNLOCK, K_REGISTER_READ_CMD, K_REGISTER_WRITE_CMD
  } cmd_kind_t;
  typedef struct packed {
    word16_t resp;
    logic [7:0] rd_cnt;
    logic [5:0] rd_base;
    logic [1:0] wl;
    logic crc_type;
    logic rx_crc_en;
    code_t [3:0] chan;
    word16_t [63:0] regs;
  } snap_t;
  typedef struct packed {
    logic started;
    logic [4:0] bit_cnt;
    logic [7:0] word_idx;
    word16_t sh;
    word16_t crc;
  } rx_t;
  typedef struct packed {
    word16_t cmd;
    logic [7:0] words;
    logic crc_bad;
    logic crc_seen;
    logic wr_tgl;
    logic [5:0] wr_addr;
    word16_t wr_data;
  } res_t;
  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [7:0] word_idx;
    logic [31:0] sh;
    word16_t crc;
    logic dout;
    logic oe;
  } tx_t;
  typedef struct packed {
    logic cs_m, cs_s, act_m, act_s, wt_m, wt_s, wt_seen;
    logic tmo;
    logic [16:0] tmo_cnt;
    logic [1:0] end_cnt;
    logic pend, locked, crc_err, resp_st;
    logic [7:0] wr_cnt;
    logic wr_v;
    logic [5:0] wr_addr;
    word16_t wr_data;
    logic rst_p, stby_p, wake_p;
    snap_t snap;
  } sys_t;
endpackage : adc_spi_pkg

// [rtl/adc_spi_regs.svh]
`ifndef ADC_SPI_REGS_SVH
`define ADC_SPI_REGS_SVH
// command words
`define CMD_NOOP 16'h0000
`define CMD_RESET 16'h0011
`define CMD_STANDBY 16'h0022
`define CMD_WAKEUP 16'h0033
`define CMD_LOCK 16'h0555
`define CMD_UNLOCK 16'h0655
`define OP_REGISTER_READ_CMD 3'h5
`define OP_REGISTER_READ_CMD_MULTI 3'h7
`define OP_REGISTER_WRITE_CMD 3'h3
`define OP_REGISTER_WRITE_CMD_ACK 3'h2
`define RESP_RESET_OK 16'hff44
`define RESP_RESET_SHORT 16'h0011
// crc
`define POLY_CCITT 16'h1021
`define POLY_ANSI 16'h8005
`define CRC_SEED 16'hffff
// framing and timing
`define TIMEOUT_MCLK 32768
`define FRAME_WORDS 8'h06
`define CHAN_WORDS 8'h04
`define CRC_WORD_STD 8'h05
`define END_DELAY 2'h3
`define WL_16 2'h0
`define WL_24 2'h1
`define WL_32_ZERO 2'h2
`define WL_32_SIGN 2'h3
// conversion codes
`define CODE_MAX 24'h7fffff
`define CODE_MIN 24'h800000
`define RAW_MAX 28'sh07fffff
`define RAW_MIN 28'shf800000
`endif

// [testbench/adc_spi_crc_command_port_properties.sv]
`timescale 1ns/1ps
module adc_spi_props #(
  parameter int unsigned TIMEOUT_CYCLES = 32768
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic dout_oe,
  input wire logic reg_wr_valid,
  input wire logic [5:0] reg_wr_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic dev_reset_req,
  input wire logic standby_req,
  input wire logic wakeup_req,
  input wire logic interface_locked,
  input wire logic crc_error_flag
);
  // ----------------------------------------
  // port relations, all on the main clock
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_wr_strobe_single: assert property (reg_wr_valid |=> !reg_wr_valid)
    else $error("write strobe longer than one cycle");
  // address and data must hold well past the strobe, writes are a word apart
  a_wr_fields_hold: assert property (
    reg_wr_valid |=> ($stable(reg_wr_addr) && $stable(reg_wr_data)) [*8])
    else $error("write address or data moved after strobe");
  a_no_write_locked: assert property (interface_locked |-> !reg_wr_valid)
    else $error("register write while locked");
  a_locked_no_pulse: assert property (
    interface_locked && $past(interface_locked) |->
    !(standby_req || wakeup_req || dev_reset_req))
    else $error("command acted while locked");
  // commands act only at decode, after chip select has gone high
  a_decode_idle: assert property (
    (dev_reset_req || standby_req || wakeup_req) |-> cs_n && $past(cs_n, 4))
    else $error("command pulse inside a frame");
  a_reset_req_single: assert property (dev_reset_req |=> !dev_reset_req ##1 !dev_reset_req)
    else $error("reset request longer than one cycle");
  a_oe_released: assert property (cs_n |-> !dout_oe)
    else $error("output driven while deselected");
  a_lock_at_decode: assert property (
    $changed(interface_locked) |-> cs_n && $past(cs_n, 3))
    else $error("lock state changed inside a frame");
  a_crc_set_decode: assert property ($rose(crc_error_flag) |-> cs_n && $past(cs_n, 3))
    else $error("crc error flag set inside a frame");
endmodule : adc_spi_props

bind adc_spi_crc_command_port adc_spi_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) adc_spi_props_inst (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .cs_n(cs_n),
  .dout_oe(dout_oe),
  .reg_wr_valid(reg_wr_valid),
  .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data),
  .dev_reset_req(dev_reset_req),
  .standby_req(standby_req),
  .wakeup_req(wakeup_req),
  .interface_locked(interface_locked),
  .crc_error_flag(crc_error_flag)
);

// [testbench/adc_spi_crc_command_port_tb.sv]
`timescale 1ns/1ps
module adc_spi_crc_command_port_tb import adc_spi_pkg::*; ;
  // ----------------------------------------
  // signals, design and host
  // ----------------------------------------
  localparam int unsigned TMO = 1024;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, cs_n, din, dout, dout_oe, reg_wr_valid, dev_reset_req, standby_req;
  logic wakeup_req, locked, crc_flag;
  logic [1:0] wl = 2'h1;
  logic rx_crc_en = 1'b0, crc_type = 1'b0, timeout_en = 1'b0, reg_wr_ok = 1'b1;
  raw_t [3:0] raw = '0;
  logic [3:0] rdy = 4'h0;
  word16_t [63:0] regs = '0;
  logic [5:0] wr_addr;
  logic [15:0] wr_data;
  logic [31:0] seed = 32'h2ff7eaec;
  logic [31:0] tw [8];
  logic [31:0] rw [8];
  logic [15:0] cmds [9];
  logic [15:0] exp [8];
  int num_errors = 0, comparisons = 0, n_wr = 0, n_rst = 0, n_stby = 0, n_wake = 0;

  adc_spi_crc_command_port #(.TIMEOUT_CYCLES(TMO)) adc_spi_crc_command_port_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .word_length_select(wl), .rx_crc_en(rx_crc_en), .crc_type(crc_type),
    .timeout_en(timeout_en), .channel_raw(raw), .channel_ready_bits(rdy), .reg_image(regs),
    .reg_wr_ok(reg_wr_ok), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(wr_addr),
    .reg_wr_data(wr_data), .dev_reset_req(dev_reset_req), .standby_req(standby_req),
    .wakeup_req(wakeup_req), .interface_locked(locked), .crc_error_flag(crc_flag));
  spi_host_model spi_host_model_inst (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

  always #5 clk_sys = ~clk_sys;
  // count accepted writes and command pulses
  always @(posedge clk_sys) begin
    if (reg_wr_valid && reg_wr_ok) n_wr++;
    if (dev_reset_req) n_rst++;
    if (standby_req) n_stby++;
    if (wakeup_req) n_wake++;
  end

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // msb first, no final inversion
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [31:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? (crc_type ? 16'h8005 : 16'h1021) : 16'h0000);
    return c;
  endfunction : crc
  function automatic int wb();
    return (wl == 2'h0) ? 16 : (wl == 2'h1) ? 24 : 32;
  endfunction : wb
  function automatic logic [31:0] al(input logic [15:0] v);
    return 32'(v) << (wb() - 16);
  endfunction : al
  function automatic logic [15:0] stat(input logic lk, input logic ce);
    return {lk, 2'b00, ce, 2'b00, wl, 4'h0, rdy};
  endfunction : stat
  function automatic logic [31:0] fmt(input raw_t r);
    logic [23:0] c;
    c = (r > 28'sh07fffff) ? 24'h7fffff : (r < -28'sh0800000) ? 24'h800000 : r[23:0];
    case (wl)
      2'h0: return {16'h0000, c[23:8]};
      2'h1: return {8'h00, c};
      2'h2: return {c, 8'h00};
      default: return {{8{c[23]}}, c};
    endcase
  endfunction : fmt

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  // send one frame; the check word is appended when input checking is on
  task automatic go(input logic [15:0] cmd, input int nw, input int junk, input logic bad);
    tw[0] = al(cmd);
    if (rx_crc_en) tw[1] = al(crc(16'hffff, tw[0], wb()) ^ 16'(bad));
    spi_host_model_inst.xfer(tw, nw, wb(), junk, rw);
    for (int k = 0; k < 8; k++)
      tw[k] = '0;
  endtask : go
  task automatic chk_crc(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int k = 0; k < n; k++)
      c = crc(c, rw[k], wb());
    chk(rw[n], al(c));
  endtask : chk_crc
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // a hang ends the run as a failure
  initial begin
    #900000;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 8; i++)
      tw[i] = '0;
    repeat (4) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (5) tick();
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      regs[i] = seed[15:0];
    end
    // two results beyond full scale, two random
    raw[0] = 28'sh0900000;
    raw[1] = 28'shf000000;
    raw[2] = {{4{seed[23]}}, seed[23:0]};
    seed = lfsr(seed);
    raw[3] = seed[27:0];
    rdy = seed[31:28];
    for (int i = 0; i < 4; i++) begin
      tick();
      wl = 2'(i ^ 1);
      crc_type = i[1];
      go(16'h0000, 6, 0, 0);
      go(16'h0000, 6, 0, 0);
      chk(rw[0], al(stat(1'b0, 1'b0)));
      for (int k = 0; k < 4; k++)
        chk(rw[k + 1], fmt(raw[k]));
      chk_crc(5);
    end
    $display("format test done");
    tick();
    wl = 2'h1;
    cmds = '{16'h0022, 16'h0033, 16'h0555, 16'h0022, 16'h0011, 16'h0655,
             {3'h5, 6'd5, 7'd0}, 16'h1234, 16'h0000};
    exp = '{16'h0022, 16'h0033, 16'h0555, stat(1'b1, 1'b0), stat(1'b1, 1'b0), 16'h0655,
            regs[5], stat(1'b0, 1'b0)};
    n_stby = 0;
    n_rst = 0;
    go(cmds[0], 6, 0, 0);
    for (int i = 1; i < 9; i++) begin
      go(cmds[i], 6, 0, 0);
      chk(rw[0], al(exp[i - 1]));
    end
    chk(32'(n_stby + n_rst), 32'd1);
    $display("command test done");
    go({3'h5, 6'd10, 7'd2}, 6, 0, 0);
    go(16'h0000, 5, 0, 0);
    chk(rw[0], al({3'h7, 6'd10, 7'd2}));
    for (int k = 0; k < 3; k++)
      chk(rw[k + 1], al(regs[10 + k]));
    chk_crc(4);
    seed = lfsr(seed);
    n_wr = 0;
    tw[1] = al(seed[15:0]);
    tw[2] = al(seed[31:16]);
    go({3'h3, 6'd20, 7'd1}, 6, 0, 0);
    chk(32'(n_wr), 32'd2);
    chk({wr_addr, wr_data}, {10'h0, 6'd21, seed[31:16]});
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al({3'h2, 6'd20, 7'd1}));
    // refused write: count minus one wraps to all ones
    tick();
    reg_wr_ok = 1'b0;
    go({3'h3, 6'd30, 7'd0}, 6, 0, 0);
    tick();
    reg_wr_ok = 1'b1;
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al({3'h2, 6'd30, 7'h7f}));
    $display("register test done");
    tick();
    rx_crc_en = 1'b1;
    go(16'h0022, 6, 0, 0);
    go(16'h0555, 6, 0, 1);
    chk(rw[0], al(16'h0022));
    chk(32'(crc_flag), 32'd1);
    chk(32'(locked), 32'd0);
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al(stat(1'b0, 1'b1)));
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al(stat(1'b0, 1'b0)));
    tick();
    rx_crc_en = 1'b0;
    $display("input check test done");
    n_rst = 0;
    go(16'h0011, 1, 0, 0);
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al(16'h0011));
    go(16'h0011, 6, 0, 0);
    chk(32'(n_rst), 32'd1);
    #2000;
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al(16'hff44));
    $display("reset test done");
    tick();
    timeout_en = 1'b1;
    n_wake = 0;
    go(16'h0033, 6, 5, 0);
    go(16'h0000, 6, 0, 0);
    chk(rw[0], al(16'h0033));
    chk(32'(n_wake), 32'd1);
    $display("timeout test done");
    finish_test();
  end
endmodule : adc_spi_crc_command_port_tb

// [testbench/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  // ----------------------------------------
  // mode 1 host, 48 ns serial clock, idle low
  // ----------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // drive after the rising edge, capture at the falling edge; an undriven
  // output is captured as unknown so it can never pass a compare
  task automatic one_bit(input logic b, output logic q);
    sclk = 1'b1;
    #2 din = b;
    #22 sclk = 1'b0;
    q = dout_oe ? dout : 1'bx;
    #24;
  endtask : one_bit

  task automatic xfer(input logic [31:0] w [8], input int nw, input int wb, input int junk,
                      output logic [31:0] r [8]);
    logic q;
    cs_n = 1'b0;
    #48;
    // stray bits then a stall just past the frame limit
    if (junk > 0) begin
      for (int i = 0; i < junk; i++)
        one_bit(i[0], q);
      #11000;
    end
    for (int k = 0; k < 8; k++)
      r[k] = '0;
    for (int k = 0; k < nw; k++)
      for (int i = wb - 1; i >= 0; i--) begin
        one_bit(w[k][i], q);
        r[k][i] = q;
      end
    // deselect; a released line shows the inverse of its last level
    cs_n = 1'b1;
    din = ~din;
    #200;
  endtask : xfer
endmodule : spi_host_model
